// File: pwm_host_ctrl.sv
/*
 * Two-wire bus master that writes and reads the wiper position register
 * of a volatile digital potentiometer.
 * Assumes pull-ups outside on both lines; the bench resolves the wires
 * from the enables. Software uses a plain strobe port, one-cycle reads.
 */
// The implementer's own choice: the strobed register port.
`default_nettype none

module pwm_host_ctrl
    import pwm_pkg::*;
#(
    parameter logic [6:0]  ID_ADDR = 7'h2A,   // Arbitrary neutral slave address
    parameter int unsigned QUARTER = QUARTER_CYC
)(
    // Clock and reset
    input  wire  logic                  i_core_clk,
    input  wire  logic                  i_srst,
    // Software register port
    input  wire  pwm_pkg::pwm_bus_req_t i_bus,
    output var   logic [31:0]           o_rdata,
    output var   logic                  o_busy,
    // Link pins, open drain
    input  wire  logic                  i_scl,
    output var   logic                  o_scl_o,
    output var   logic                  o_scl_oe,
    input  wire  logic                  i_sda,
    output var   logic                  o_sda_o,
    output var   logic                  o_sda_oe
);
    import pwm_pkg::*;

    localparam logic [15:0] Q_LAST = 16'(QUARTER - 1);

    pwm_state_t  state_ff, nxt_state;
    logic [1:0]  q_ff, nxt_q;
    logic [2:0]  bit_ff, nxt_bit;
    logic [7:0]  sh_ff, nxt_sh;
    logic [1:0]  step_ff, nxt_step;
    logic        rd_mode_ff, nxt_rd_mode;
    logic [7:0]  left_ff, nxt_left;
    logic [7:0]  rcnt_ff, nxt_rcnt;
    logic        ackn_ff, nxt_ackn;
    logic        nack_ff, done_ff;
    logic        nack_set, done_set;
    logic [6:0]  wiper_wr_ff;
    logic [7:0]  addr_byte_ff;
    logic [6:0]  rd_wiper_ff, nxt_rd_wiper;
    logic [15:0] div_ff;
    logic        scl_m_ff, scl_s_ff, sda_m_ff, sda_s_ff;

    // Byte sent at each step of a transfer
    function automatic logic [7:0] tx_byte(input logic [1:0] step, input logic rd,
                                           input logic [7:0] adr, input logic [6:0] wip);
        logic [7:0] b;
        b = {1'b0, wip};                          // Top bit of data kept zero
        if (step == 2'd0)
            b = {ID_ADDR, 1'b0};
        else if (step == 2'd1)
            b = adr;
        else if (rd)
            b = {ID_ADDR, 1'b1};
        return b;
    endfunction

    // Port decode
    wire idle     = (state_ff == ST_IDLE);
    wire wr_ctrl  = i_bus.we & (i_bus.addr == REG_CTRL);
    wire wr_wdata = i_bus.we & (i_bus.addr == REG_WDATA);
    wire wr_stat  = i_bus.we & (i_bus.addr == REG_STATUS);
    wire go_wr    = wr_ctrl & idle & i_bus.wdata[CTRL_GO_WR];
    wire go_rd    = wr_ctrl & idle & i_bus.wdata[CTRL_GO_RD] & ~i_bus.wdata[CTRL_GO_WR];
    wire [7:0] req_cnt = i_bus.wdata[CTRL_CNT_LO +: 8];

    // Quarter tick; stalls while a released clock is still held low
    wire stretch = ~o_scl_oe & ~scl_s_ff & ~idle;
    wire tick    = (div_ff == Q_LAST) & ~stretch;
    wire last_q  = tick & (q_ff == 2'd3);
    wire samp    = tick & (q_ff == 2'd2);

    // Pin levels wanted for the current quarter
    wire data_st  = (state_ff == ST_TX) | (state_ff == ST_RX) |
                    (state_ff == ST_ACK) | (state_ff == ST_MACK);
    wire nxt_scl_oe = ~idle & ~q_ff[1];           // Clock low in quarters 0 and 1
    wire sda_want = ((state_ff == ST_START) & (q_ff == 2'd3)) |
                    ((state_ff == ST_TX) & ~sh_ff[7]) |
                    ((state_ff == ST_MACK) & (left_ff != 8'h00)) |
                    ((state_ff == ST_STOP) & ((q_ff == 2'd1) | (q_ff == 2'd2)));
    // Hold data in quarter 0 so it never moves on the clock's falling edge
    wire nxt_sda_oe = idle ? 1'b0 :
                      (q_ff == 2'd0) ? o_sda_oe : sda_want;

    // Read mux
    wire [31:0] rd_mux =
        (i_bus.addr == REG_WDATA)  ? {16'h0000, addr_byte_ff, 1'b0, wiper_wr_ff} :
        (i_bus.addr == REG_STATUS) ? {29'h0000_0000, done_ff, nack_ff, ~idle} :
        (i_bus.addr == REG_RDATA)  ? {16'h0000, rcnt_ff, 1'b0, rd_wiper_ff} :
                                     32'h0000_0000;

    // Sequencer next state
    always_comb
    begin
        nxt_state    = state_ff;
        nxt_q        = tick ? q_ff + 2'd1 : q_ff;
        nxt_bit      = bit_ff;
        nxt_sh       = sh_ff;
        nxt_step     = step_ff;
        nxt_rd_mode  = rd_mode_ff;
        nxt_left     = left_ff;
        nxt_rcnt     = rcnt_ff;
        nxt_ackn     = ackn_ff;
        nxt_rd_wiper = rd_wiper_ff;
        nack_set     = 1'b0;
        done_set     = 1'b0;
        unique case (state_ff)
            ST_IDLE:
            begin
                nxt_q = 2'd0;
                if (go_wr | go_rd)
                begin
                    nxt_state   = ST_START;
                    nxt_step    = 2'd0;
                    nxt_rd_mode = go_rd;
                    nxt_left    = (req_cnt == 8'h00) ? 8'h01 : req_cnt;
                    nxt_rcnt    = 8'h00;
                end
            end
            ST_START:
                if (last_q)
                begin
                    nxt_state = ST_TX;
                    nxt_bit   = 3'd0;
                    nxt_sh    = tx_byte(step_ff, rd_mode_ff, addr_byte_ff, wiper_wr_ff);
                end
            ST_TX:
                if (last_q)
                begin
                    nxt_sh  = {sh_ff[6:0], 1'b0};
                    nxt_bit = bit_ff + 3'd1;
                    if (bit_ff == 3'd7)
                        nxt_state = ST_ACK;
                end
            ST_ACK:
            begin
                if (samp)
                    nxt_ackn = sda_s_ff;
                if (last_q)
                begin
                    nxt_bit = 3'd0;
                    if (ackn_ff)
                    begin
                        nack_set  = 1'b1;
                        nxt_state = ST_STOP;
                    end
                    else if (!rd_mode_ff && step_ff == 2'd2)
                        nxt_state = ST_STOP;
                    else if (rd_mode_ff && step_ff == 2'd1)
                    begin
                        nxt_state = ST_START;
                        nxt_step  = 2'd2;
                    end
                    else if (rd_mode_ff && step_ff == 2'd2)
                        nxt_state = ST_RX;
                    else
                    begin
                        nxt_state = ST_TX;
                        nxt_step  = step_ff + 2'd1;
                        nxt_sh    = tx_byte(step_ff + 2'd1, rd_mode_ff, addr_byte_ff,
                                            wiper_wr_ff);
                    end
                end
            end
            ST_RX:
            begin
                if (samp)
                    nxt_sh = {sh_ff[6:0], sda_s_ff};
                if (last_q)
                begin
                    nxt_bit = bit_ff + 3'd1;
                    if (bit_ff == 3'd7)
                    begin
                        nxt_state    = ST_MACK;
                        nxt_left     = left_ff - 8'h01;
                        nxt_rcnt     = rcnt_ff + 8'h01;
                        nxt_rd_wiper = sh_ff[6:0];
                    end
                end
            end
            ST_MACK:
                if (last_q)
                begin
                    nxt_bit   = 3'd0;
                    nxt_state = (left_ff == 8'h00) ? ST_STOP : ST_RX;
                end
            ST_STOP:
                if (last_q)
                begin
                    nxt_state = ST_IDLE;
                    done_set  = 1'b1;
                end
        endcase
    end

    // Input synchronisers
    always_ff @(posedge i_core_clk)
    begin
        scl_m_ff <= i_scl;
        scl_s_ff <= scl_m_ff;
        sda_m_ff <= i_sda;
        sda_s_ff <= sda_m_ff;
    end

    // Quarter divider; restarts at every tick
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst || idle || tick)
            div_ff <= 16'h0000;
        else if (!stretch)
            div_ff <= div_ff + 16'h0001;
    end

    // Sequencer registers
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            state_ff    <= ST_IDLE;
            q_ff        <= 2'd0;
            bit_ff      <= 3'd0;
            sh_ff       <= 8'h00;
            step_ff     <= 2'd0;
            rd_mode_ff  <= 1'b0;
            left_ff     <= 8'h00;
            rcnt_ff     <= 8'h00;
            ackn_ff     <= 1'b0;
            rd_wiper_ff <= WIPER_RESET;
        end
        else
        begin
            state_ff    <= nxt_state;
            q_ff        <= nxt_q;
            bit_ff      <= nxt_bit;
            sh_ff       <= nxt_sh;
            step_ff     <= nxt_step;
            rd_mode_ff  <= nxt_rd_mode;
            left_ff     <= nxt_left;
            rcnt_ff     <= nxt_rcnt;
            ackn_ff     <= nxt_ackn;
            rd_wiper_ff <= nxt_rd_wiper;
        end
    end

    // Software registers; flag set beats a same-cycle clear
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            wiper_wr_ff  <= WIPER_RESET;
            addr_byte_ff <= WIPER_ADDR;
            nack_ff      <= 1'b0;
            done_ff      <= 1'b0;
        end
        else
        begin
            if (wr_wdata && idle)   // Frozen mid-transfer so the byte stays coherent
            begin
                wiper_wr_ff  <= i_bus.wdata[6:0];
                addr_byte_ff <= i_bus.wdata[FLD_HI_LO +: 8];
            end
            nack_ff <= nack_set | (nack_ff & ~(wr_stat & i_bus.wdata[STAT_NACK]));
            done_ff <= done_set | (done_ff & ~(wr_stat & i_bus.wdata[STAT_DONE]));
        end
    end

    // Registered outputs
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            o_rdata  <= 32'h0000_0000;
            o_busy   <= 1'b0;
            o_scl_o  <= 1'b0;
            o_scl_oe <= 1'b0;
            o_sda_o  <= 1'b0;
            o_sda_oe <= 1'b0;
        end
        else
        begin
            o_rdata  <= i_bus.re ? rd_mux : 32'h0000_0000;
            o_busy   <= ~(nxt_state == ST_IDLE);
            o_scl_o  <= 1'b0;
            o_scl_oe <= nxt_scl_oe;
            o_sda_o  <= 1'b0;
            o_sda_oe <= nxt_sda_oe;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    chk_msb_first_out: assert property (
        (state_ff == ST_TX && q_ff == 2'd2) |-> (o_sda_oe == ~sh_ff[7]))
        else $error("transmitted bit is not the top bit of the shifter");

    chk_sda_still_high: assert property (
        (data_st && !o_scl_oe && $past(!o_scl_oe) && $stable(state_ff))
        |-> $stable(o_sda_oe))
        else $error("data line moved while clock was high");

    chk_ack_released: assert property (
        (state_ff == ST_ACK && q_ff[1]) |-> !o_sda_oe)
        else $error("data line held during slave acknowledge");

    chk_stop_frees_bus: assert property (
        (state_ff == ST_STOP && last_q) |=> (idle && !o_scl_oe && !o_sda_oe))
        else $error("stop did not leave both lines released");

    chk_master_ack_low: assert property (
        (state_ff == ST_MACK && q_ff[1] && left_ff != 8'h00) |-> o_sda_oe)
        else $error("master failed to acknowledge a read byte");

    chk_last_byte_nack: assert property (
        (state_ff == ST_MACK && q_ff[1] && left_ff == 8'h00)
        |-> (!o_sda_oe ##[1:40] state_ff == ST_STOP))
        else $error("last read byte not ended by release and stop");

    chk_read_id_dir: assert property (
        (state_ff == ST_START && last_q && step_ff == 2'd2)
        |=> (sh_ff == {ID_ADDR, 1'b1}))
        else $error("repeated start not followed by read identification");

    chk_write_three: assert property (
        (state_ff == ST_ACK && last_q && !rd_mode_ff && step_ff == 2'd2 && !ackn_ff)
        |=> (state_ff == ST_STOP))
        else $error("write did not stop after its data byte");

    chk_go_starts: assert property (
        (go_wr || go_rd) |=> (state_ff == ST_START && o_busy) ##1 o_scl_oe)
        else $error("accepted command did not start the link");

endmodule // pwm_host_ctrl

`default_nettype wire

// File: pwm_pkg.sv
/*
 * Constants, register map and carrier types of the two-wire wiper host.
 * Assumes a 10 MHz core clock and a single open-drain two-wire link.
 */
`default_nettype none

package pwm_pkg;

    // Core clock and link timing
    localparam int unsigned CORE_CLK_HZ = 10_000_000;
    localparam int unsigned QUARTER_NS  = 700;   // Each quarter of a link clock period
    localparam int unsigned QUARTER_CYC =
        (QUARTER_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;

    // Host register offsets (byte addresses)
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_WDATA  = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_RDATA  = 4'hC;

    // Field positions
    localparam int unsigned CTRL_GO_WR  = 0;
    localparam int unsigned CTRL_GO_RD  = 1;
    localparam int unsigned CTRL_CNT_LO = 8;
    localparam int unsigned STAT_BUSY   = 0;
    localparam int unsigned STAT_NACK   = 1;
    localparam int unsigned STAT_DONE   = 2;
    localparam int unsigned FLD_HI_LO   = 8;

    // Values after reset and device map
    localparam logic [6:0] WIPER_RESET = 7'h40;   // Mid-scale, matches device preset
    localparam logic [7:0] WIPER_ADDR  = 8'h00;   // Offset of the wiper position register

    // Request from the software port
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        we;
        logic        re;
    } pwm_bus_req_t;

    // Link sequencer states
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_START = 7'h02,
        ST_TX    = 7'h04,
        ST_ACK   = 7'h08,
        ST_RX    = 7'h10,
        ST_MACK  = 7'h20,
        ST_STOP  = 7'h40
    } pwm_state_t;

endpackage

`default_nettype wire

// File: pwm_dev_model.sv
/*
 * Behavioural model of the wiper device on the two-wire link, slave only.
 * Assumes both lines are resolved outside with pull-ups; i_rst is power-up.
 */
`default_nettype none

module pwm_dev_model (
    // Power-up and setup
    input  wire logic       i_rst,
    input  wire logic [6:0] i_id_addr,
    input  wire logic       i_slow,
    // Link lines
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output var  logic       o_scl_oe,
    output var  logic       o_sda_oe,
    // Wiper position
    output var  logic [6:0] o_wiper
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] sh;
    logic [7:0] tx;
    logic       mack;
    int         ph;   // 0 idle, 1 id, 2 addr, 3 wdata, 4 rdata, 5 wait
    int         nph;
    int         bitn;

    task automatic pwr_up();
        ph       = 0;
        bitn     = 0;
        o_sda_oe = 1'b0;
        o_scl_oe = 1'b0;
        o_wiper  = 7'h40;
    endtask

    // Power-up: lines released, wiper preset to mid-scale
    initial pwr_up();
    always @(posedge i_rst) pwr_up();

    // Start aborts any byte; starts during power-up are ignored
    always @(negedge i_sda) if (i_scl === 1'b1 && !i_rst)
    begin
        ph       = 1;
        bitn     = 0;
        o_sda_oe = 1'b0;
    end

    // Stop returns to idle
    always @(posedge i_sda) if (i_scl === 1'b1)
    begin
        ph       = 0;
        o_sda_oe = 1'b0;
    end

    // Sample on the rising clock, most significant bit first
    always @(posedge i_scl) if (ph inside {[1:4]})
    begin
        if (bitn == 8)
        begin
            mack = !i_sda;
            bitn = 9;
        end
        else if (bitn < 8)
        begin
            sh   = {sh[6:0], i_sda};
            bitn = bitn + 1;
        end
    end

    // Drive only after a falling clock, so data never moves while clock high
    always @(negedge i_scl) if (ph inside {[1:4]})
    begin
        if (bitn == 8 && ph != 4)
        begin
            nph = (ph == 1) ? (sh[0] ? 4 : 2) : (ph == 2) ? 3 : 5;
            o_sda_oe = (ph == 1) ? (sh[7:1] == i_id_addr) :
                       (ph == 2) ? (sh == 8'h00) : 1'b1;
            if (ph == 3)
                o_wiper = sh[6:0];
            if (!o_sda_oe)
                ph = 5;
        end
        else if (bitn == 8)
            o_sda_oe = 1'b0;
        else if (bitn == 9)
        begin
            bitn     = 0;
            o_sda_oe = 1'b0;
            ph       = (ph == 4) ? (mack ? 4 : 5) : nph;
            if (ph == 4)
            begin
                tx       = {1'b0, o_wiper};
                o_sda_oe = !tx[7];
            end
            // Slow answer: hold the clock low to stretch the next bit
            if (i_slow)
            begin
                o_scl_oe = 1'b1;
                #1500;
                o_scl_oe = 1'b0;
            end
        end
        else if (ph == 4 && bitn > 0)
            o_sda_oe = !tx[7 - bitn];
    end

endmodule // pwm_dev_model

`default_nettype wire

// File: testbench.sv
/*
 * Self-checking bench for the two-wire wiper host with a device model.
 * Assumes pull-ups on both lines, resolved here from every enable.
 */
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import pwm_pkg::*;

    logic         clk = 1'b0;
    logic         srst = 1'b1;
    logic         slow = 1'b0;
    logic [6:0]   id = 7'h2A;   // Arbitrary neutral slave address
    pwm_bus_req_t bus = '0;
    logic [31:0]  rdata, d, st;
    logic         busy, scl_oe, sda_oe, d_scl_oe, d_sda_oe, scl_o, sda_o;
    logic [6:0]   wiper;
    int           bad_count = 0;
    int           n_checks = 0;
    int           cyc = 0;
    // Open-drain wires: low while anyone pulls
    wire logic    scl = !(scl_oe || d_scl_oe);
    wire logic    sda = !(sda_oe || d_sda_oe);

    // Rows: address byte, value, nack expected, wiper afterwards
    logic [7:0] t_ab [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h80};
    logic [6:0] t_v  [5] = '{7'h7F, 7'h00, 7'h55, 7'h12, 7'h2B};
    logic       t_nk [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [6:0] t_w  [5] = '{7'h7F, 7'h00, 7'h55, 7'h55, 7'h55};

    // Small quarter: link clock near 1 us once the sync stalls are counted
    pwm_host_ctrl #(.ID_ADDR(7'h2A), .QUARTER(2)) u_pwm_host_ctrl (
        .i_core_clk(clk), .i_srst(srst), .i_bus(bus), .o_rdata(rdata), .o_busy(busy),
        .i_scl(scl), .o_scl_o(scl_o), .o_scl_oe(scl_oe),
        .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe));

    pwm_dev_model u_pwm_dev_model (
        .i_rst(srst), .i_id_addr(id), .i_slow(slow), .i_scl(scl), .i_sda(sda),
        .o_scl_oe(d_scl_oe), .o_sda_oe(d_sda_oe), .o_wiper(wiper));

    // Core clock, 100 ns
    initial forever #50 clk = ~clk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Hang guard, far above the expected run
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            bad_count++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle strobes, changed just after the edge
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
        @(posedge clk);
        bus.we <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
        @(posedge clk);
        bus.re <= 1'b0;
        #1 v = rdata;
    endtask

    // Go, wait for idle (a hang falls to the cycle ceiling), fetch and clear status
    task automatic xfer(input logic [31:0] ctrl, output logic [31:0] s);
        wr(REG_CTRL, ctrl);
        repeat (2) @(negedge clk);
        chk("busy", 32'h1, {29'h0, scl_o, sda_o, busy});
        while (busy !== 1'b0) @(negedge clk);
        rd(REG_STATUS, s);
        wr(REG_STATUS, 32'h6);
    endtask

    task automatic wr_wiper(input logic [7:0] ab, input logic [6:0] v);
        wr(REG_WDATA, {16'h0, ab, 1'b0, v});
        xfer(32'h1, st);
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        // Reset values
        rd(REG_STATUS, d);
        chk("status reset", 32'h0, d);
        rd(REG_RDATA, d);
        chk("rdata reset", 32'h40, d);
        rd(4'h2, d);
        chk("unmapped read", 32'h0, d);
        chk("wiper preset", 32'h40, {25'h0, wiper});
        xfer(32'h2, st);
        rd(REG_RDATA, d);
        chk("first read", 32'h0140, d & 32'hFF7F);
        // Ordinary writes, each read back over the link
        for (int k = 0; k < 5; k++)
        begin
            wr_wiper(t_ab[k], t_v[k]);
            chk("write status", {29'h0, 1'b1, t_nk[k], 1'b0}, st);
            chk("model wiper", {25'h0, t_w[k]}, {25'h0, wiper});
            wr(REG_WDATA, 32'h0);   // Address byte 00h, else the read is refused too
            xfer(32'h2, st);
            rd(REG_RDATA, d);
            chk("read back", {16'h1, 1'b0, t_w[k]}, d & 32'hFF7F);
        end
        // Three bytes in one read
        xfer(32'h0302, st);
        chk("read status", 32'h4, st);
        rd(REG_RDATA, d);
        chk("multi read", 32'h0355, d & 32'hFF7F);
        // Wrong identification: no acknowledge, wiper kept
        id <= 7'h2B;
        wr_wiper(8'h00, 7'h11);
        chk("id nack", 32'h6, st);
        chk("wiper kept", 32'h55, {25'h0, wiper});
        id <= 7'h2A;
        // Slow device stretching the clock
        slow <= 1'b1;
        wr_wiper(8'h00, 7'h3C);
        chk("slow write", 32'h3C, {25'h0, wiper});
        xfer(32'h2, st);
        rd(REG_RDATA, d);
        chk("slow read", 32'h013C, d & 32'hFF7F);
        slow <= 1'b0;
        // Go and data while busy are refused
        wr(REG_WDATA, 32'h21);
        wr(REG_CTRL, 32'h1);
        wr(REG_WDATA, 32'h7E);
        xfer(32'h1, st);
        chk("one write only", 32'h21, {25'h0, wiper});
        rd(REG_WDATA, d);
        chk("wdata kept", 32'h21, d);
        // Reset in mid-write
        wr(REG_WDATA, 32'h0A);
        wr(REG_CTRL, 32'h1);
        repeat (60) @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(negedge clk);
        chk("reset lines", 32'h0, {27'h0, busy, scl_oe, sda_oe, d_scl_oe, d_sda_oe});
        chk("reset wiper", 32'h40, {25'h0, wiper});
        @(posedge clk);
        srst <= 1'b0;
        wr_wiper(8'h00, 7'h0A);
        chk("after reset", 32'h0A, {25'h0, wiper});
        close_out();
    end

endmodule // testbench

`default_nettype wire
